// [src/pin_task_event_regs.svh]
/*
  Register offsets, field positions, reset values and sizes of the pin
  task/event unit.
  Assumes inclusion by bare name from the package; the design modules use its macros without including it.
*/
`ifndef PIN_TASK_EVENT_REGS_SVH
`define PIN_TASK_EVENT_REGS_SVH

// ************************************************************
// sizes
// ************************************************************
`define NUM_CHANNELS 8
`define NUM_PINS 32
`define NUM_IC_CHANNELS 256
`define PSEL_W 5
`define IC_IDX_W 8

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_OUT_TASK 12'h000
`define OFS_SET_TASK 12'h030
`define OFS_CLR_TASK 12'h060
`define OFS_OUT_SUB 12'h080
`define OFS_SET_SUB 12'h0B0
`define OFS_CLR_SUB 12'h0E0
`define OFS_IN_EVENT 12'h100
`define OFS_PORT_EVENT 12'h17C
`define OFS_IN_PUB 12'h180
`define OFS_PORT_PUB 12'h1FC
`define OFS_INT_SET 12'h304
`define OFS_INT_CLR 12'h308
`define OFS_INT_STATUS 12'h30C
`define OFS_CONFIG 12'h510
`define ARRAY_SPAN 12'h020

// ************************************************************
// field positions and reset values
// ************************************************************
`define CFG_MODE_LSB 0
`define CFG_PSEL_LSB 8
`define CFG_POL_LSB 16
`define CFG_INITIAL_OUTPUT_LEVEL_BIT 20
`define SUB_EN_BIT 31
`define INT_PORT_BIT 31
`define RESET_WORD 32'h0000_0000

`endif

// [src/pin_task_event_pkg.sv]
/*
  Types shared by the pin task/event unit and its channel helpers.
  Assumes the constants header is on the include path.
*/
package pin_task_event_pkg;
  `include "pin_task_event_regs.svh"

  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TASK = 2'h3
  } chan_mode_t;

  typedef enum logic [1:0] {
    POL_NONE,
    POL_LO_TO_HI,
    POL_HI_TO_LO,
    POL_TOGGLE
  } polarity_t;

  typedef logic [`PSEL_W-1:0] pin_sel_t;
endpackage : pin_task_event_pkg

// [src/channel_task_drive.sv]
/*
  Output level of one channel in task mode, with task priority.
  Assumes one-cycle trigger pulses and a mode that the parent decodes.
*/
`timescale 1ns/100ps
module channel_task_drive
  import pin_task_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic taskMode,
  input wire logic initial_output_level,
  input polarity_t polarity,
  input wire logic outTrig,
  input wire logic setTrig,
  input wire logic clrTrig,
  output logic level
);
  logic wasTask_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wasTask_reg <= 1'b0;
    end else begin
      wasTask_reg <= taskMode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (taskMode && !wasTask_reg) begin
      level <= initial_output_level;
    end else if (taskMode && outTrig) begin
      // out task outranks clear and set; none then leaves the pin alone
      unique case (polarity)
        POL_NONE: level <= level;
        POL_LO_TO_HI: level <= 1'b1;
        POL_HI_TO_LO: level <= 1'b0;
        POL_TOGGLE: level <= ~level;
      endcase
    end else if (taskMode && clrTrig) begin
      level <= 1'b0;
    end else if (taskMode && setTrig) begin
      level <= 1'b1;
    end
  end
endmodule : channel_task_drive

// [src/channel_edge_detect.sv]
/*
  Edge detector of one channel in event mode.
  Assumes the pin level is synchronous to clk.
*/
`timescale 1ns/100ps
module channel_edge_detect
  import pin_task_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic eventMode,
  input polarity_t polarity,
  input wire logic pinLevel,
  output logic detected
);
  logic prev_reg;
  logic armed_reg;

  // armed one cycle after entry so a stale sample raises no event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= pinLevel;
      armed_reg <= eventMode;
    end
  end

  always_comb begin
    detected = 1'b0;
    if (eventMode && armed_reg) begin
      unique case (polarity)
        POL_NONE: detected = 1'b0;
        POL_LO_TO_HI: detected = pinLevel && !prev_reg;
        POL_HI_TO_LO: detected = !pinLevel && prev_reg;
        POL_TOGGLE: detected = pinLevel != prev_reg;
      endcase
    end
  end
endmodule : channel_edge_detect

// [src/pin_task_event_unit.sv]
/*
  Pin task/event unit: eight channels binding tasks and events to pins,
  APB register slave, interconnect subscribe/publish, port event, interrupt.
  Assumes pins and the sense detect level are synchronous to clk, and
  interconnect channels arrive as one-cycle pulses.
*/
// Implementation choice: the APB slave port.
// How it works
// - each channel acts only on the pin its pin-select field names
// - event mode forces the selected pin to input
// - task mode forces the pin to output, driven by the channel
// - disabled mode passes the general pin controller's settings through
// - pin select changes only while the channel is disabled
// - writing one to the output task applies the polarity action
// - writing one to the set task drives the pin high
// - writing one to the clear task drives the pin low
// - set subscription holds channel index and enable bit
// - clear subscription holds channel index and enable bit
// - each channel records pin events in a clearable register
// - port event set on rising edge of the sense detect signal
// - same-cycle conflict: output beats clear, clear beats set
// - polarity makes output task drive high, low or toggle
// - event mode detects rising, falling or any edge per polarity
// - entering task mode drives the pin one cycle at the old channel level, then at the initial level
`timescale 1ns/100ps
module pin_task_event_unit
  import pin_task_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`NUM_PINS-1:0] pinIn,
  output logic [`NUM_PINS-1:0] pinOut,
  output logic [`NUM_PINS-1:0] pinOe,
  input wire logic [`NUM_PINS-1:0] gpioPinConfigDir,
  input wire logic [`NUM_PINS-1:0] gpioPinConfigOut,
  input wire logic senseDetect,
  input wire logic [`NUM_IC_CHANNELS-1:0] icChannelIn,
  output logic [`NUM_IC_CHANNELS-1:0] icChannelOut,
  output logic irq
);
  localparam int NCH = `NUM_CHANNELS;

  // ************************************************************
  // state
  // ************************************************************
  chan_mode_t mode_reg [NCH];
  pin_sel_t pinSel_reg [NCH];
  polarity_t pol_reg [NCH];
  logic [NCH-1:0] initialOutputLevel_reg;
  logic [8:0] subOut_reg [NCH];
  logic [8:0] subSet_reg [NCH];
  logic [8:0] subClr_reg [NCH];
  logic [8:0] pubIn_reg [NCH];
  logic [8:0] pubPort_reg;
  logic [NCH-1:0] inEvent_reg;
  logic portEvent_reg;
  logic detectPrev_reg;
  logic [NCH:0] intEn_reg;
  logic [NCH:0] intStat_reg;
  logic [NCH-1:0] level;
  logic [NCH-1:0] detected;
  logic [NCH-1:0] outTrig;
  logic [NCH-1:0] setTrig;
  logic [NCH-1:0] clrTrig;
  logic portDetected;
  logic [11:0] addr;
  logic apbDone;
  logic wrDone;
  logic rdDone;
  logic [31:0] rdData;
  logic rdErr;
  logic [NCH:0] eventsNow;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic arrHit(input logic [11:0] a, input logic [11:0] base);
    return (a >= base) && (a < base + `ARRAY_SPAN) && (a[1:0] == 2'h0);
  endfunction : arrHit

  function automatic logic [2:0] arrIdx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[4:2];
  endfunction : arrIdx

  function automatic logic chHit(input logic [11:0] a, input logic [11:0] base,
                                 input int c);
    return arrHit(a, base) && (arrIdx(a, base) == c[2:0]);
  endfunction : chHit

  function automatic logic subFires(input logic [8:0] sub,
                                    input logic [`NUM_IC_CHANNELS-1:0] ic);
    return sub[8] && ic[sub[7:0]];
  endfunction : subFires

  function automatic chan_mode_t toMode(input logic [1:0] v);
    chan_mode_t m;
    m = MODE_DISABLED;
    if (v == 2'h1) m = MODE_EVENT;
    if (v == 2'h3) m = MODE_TASK;
    return m;
  endfunction : toMode

  assign addr = paddr;
  assign apbDone = psel && penable && pready;
  assign wrDone = apbDone && pwrite;
  assign rdDone = apbDone && !pwrite;

  // ************************************************************
  // apb slave: one wait state, answer registered
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= `RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rdData : `RESET_WORD;
      pslverr <= psel && penable && !pready && rdErr;
    end
  end

  always_comb begin
    rdData = `RESET_WORD;
    rdErr = 1'b0;
    if (arrHit(addr, `OFS_OUT_TASK) || arrHit(addr, `OFS_SET_TASK) ||
        arrHit(addr, `OFS_CLR_TASK)) begin
      rdData = `RESET_WORD;
    end else if (arrHit(addr, `OFS_OUT_SUB)) begin
      rdData = {subOut_reg[arrIdx(addr, `OFS_OUT_SUB)][8], 23'h0,
                subOut_reg[arrIdx(addr, `OFS_OUT_SUB)][7:0]};
    end else if (arrHit(addr, `OFS_SET_SUB)) begin
      rdData = {subSet_reg[arrIdx(addr, `OFS_SET_SUB)][8], 23'h0,
                subSet_reg[arrIdx(addr, `OFS_SET_SUB)][7:0]};
    end else if (arrHit(addr, `OFS_CLR_SUB)) begin
      rdData = {subClr_reg[arrIdx(addr, `OFS_CLR_SUB)][8], 23'h0,
                subClr_reg[arrIdx(addr, `OFS_CLR_SUB)][7:0]};
    end else if (arrHit(addr, `OFS_IN_EVENT)) begin
      rdData = {31'h0, inEvent_reg[arrIdx(addr, `OFS_IN_EVENT)]};
    end else if (addr == `OFS_PORT_EVENT) begin
      rdData = {31'h0, portEvent_reg};
    end else if (arrHit(addr, `OFS_IN_PUB)) begin
      rdData = {pubIn_reg[arrIdx(addr, `OFS_IN_PUB)][8], 23'h0,
                pubIn_reg[arrIdx(addr, `OFS_IN_PUB)][7:0]};
    end else if (addr == `OFS_PORT_PUB) begin
      rdData = {pubPort_reg[8], 23'h0, pubPort_reg[7:0]};
    end else if (addr == `OFS_INT_SET || addr == `OFS_INT_CLR) begin
      rdData = {intEn_reg[NCH], 23'h0, intEn_reg[NCH-1:0]};
    end else if (addr == `OFS_INT_STATUS) begin
      rdData = {intStat_reg[NCH], 23'h0, intStat_reg[NCH-1:0]};
    end else if (arrHit(addr, `OFS_CONFIG)) begin
      rdData = {11'h0, initialOutputLevel_reg[arrIdx(addr, `OFS_CONFIG)], 2'h0,
                pol_reg[arrIdx(addr, `OFS_CONFIG)], 3'h0,
                pinSel_reg[arrIdx(addr, `OFS_CONFIG)], 6'h0,
                mode_reg[arrIdx(addr, `OFS_CONFIG)]};
    end else begin
      rdErr = 1'b1;
    end
  end

  // ************************************************************
  // task triggers: register write or subscribed interconnect pulse
  // ************************************************************
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      outTrig[c] = (wrDone && chHit(addr, `OFS_OUT_TASK, c) && pwdata[0]) ||
                   subFires(subOut_reg[c], icChannelIn);
      setTrig[c] = (wrDone && chHit(addr, `OFS_SET_TASK, c) && pwdata[0]) ||
                   subFires(subSet_reg[c], icChannelIn);
      clrTrig[c] = (wrDone && chHit(addr, `OFS_CLR_TASK, c) && pwdata[0]) ||
                   subFires(subClr_reg[c], icChannelIn);
    end
  end

  // ************************************************************
  // channels
  // ************************************************************
  for (genvar g = 0; g < NCH; g++) begin : gen_chan
    channel_task_drive u_drive (
      .clk(clk),
      .rst(rst),
      .taskMode(mode_reg[g] == MODE_TASK),
      .initial_output_level(initialOutputLevel_reg[g]),
      .polarity(pol_reg[g]),
      .outTrig(outTrig[g]),
      .setTrig(setTrig[g]),
      .clrTrig(clrTrig[g]),
      .level(level[g])
    );
    channel_edge_detect u_edge (
      .clk(clk),
      .rst(rst),
      .eventMode(mode_reg[g] == MODE_EVENT),
      .polarity(pol_reg[g]),
      .pinLevel(pinIn[pinSel_reg[g]]),
      .detected(detected[g])
    );
  end

  // ************************************************************
  // configuration and subscription registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        mode_reg[c] <= MODE_DISABLED;
        pinSel_reg[c] <= '0;
        pol_reg[c] <= POL_NONE;
        initialOutputLevel_reg[c] <= 1'b0;
        subOut_reg[c] <= 9'h000;
        subSet_reg[c] <= 9'h000;
        subClr_reg[c] <= 9'h000;
        pubIn_reg[c] <= 9'h000;
      end
      pubPort_reg <= 9'h000;
    end else if (wrDone) begin
      for (int c = 0; c < NCH; c++) begin
        if (chHit(addr, `OFS_CONFIG, c)) begin
          mode_reg[c] <= toMode(pwdata[`CFG_MODE_LSB +: 2]);
          // pin select frozen unless disabled; a moving pin would glitch
          if (mode_reg[c] == MODE_DISABLED) begin
            pinSel_reg[c] <= pwdata[`CFG_PSEL_LSB +: `PSEL_W];
          end
          pol_reg[c] <= polarity_t'(pwdata[`CFG_POL_LSB +: 2]);
          initialOutputLevel_reg[c] <= pwdata[`CFG_INITIAL_OUTPUT_LEVEL_BIT];
        end
        if (chHit(addr, `OFS_OUT_SUB, c)) begin
          subOut_reg[c] <= {pwdata[`SUB_EN_BIT], pwdata[7:0]};
        end
        if (chHit(addr, `OFS_SET_SUB, c)) begin
          subSet_reg[c] <= {pwdata[`SUB_EN_BIT], pwdata[7:0]};
        end
        if (chHit(addr, `OFS_CLR_SUB, c)) begin
          subClr_reg[c] <= {pwdata[`SUB_EN_BIT], pwdata[7:0]};
        end
        if (chHit(addr, `OFS_IN_PUB, c)) begin
          pubIn_reg[c] <= {pwdata[`SUB_EN_BIT], pwdata[7:0]};
        end
      end
      if (addr == `OFS_PORT_PUB) begin
        pubPort_reg <= {pwdata[`SUB_EN_BIT], pwdata[7:0]};
      end
    end
  end

  // ************************************************************
  // events: hardware set wins over software write
  // ************************************************************
  assign portDetected = senseDetect && !detectPrev_reg;
  assign eventsNow = {portDetected, detected};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inEvent_reg <= '0;
      portEvent_reg <= 1'b0;
      // starts high so a sense level already up at release raises no event
      detectPrev_reg <= 1'b1;
    end else begin
      detectPrev_reg <= senseDetect;
      for (int c = 0; c < NCH; c++) begin
        if (detected[c]) begin
          inEvent_reg[c] <= 1'b1;
        end else if (wrDone && chHit(addr, `OFS_IN_EVENT, c)) begin
          inEvent_reg[c] <= pwdata[0];
        end
      end
      if (portDetected) begin
        portEvent_reg <= 1'b1;
      end else if (wrDone && addr == `OFS_PORT_EVENT) begin
        portEvent_reg <= pwdata[0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      icChannelOut <= '0;
    end else begin
      icChannelOut <= '0;
      for (int c = 0; c < NCH; c++) begin
        if (detected[c] && pubIn_reg[c][8]) begin
          icChannelOut[pubIn_reg[c][7:0]] <= 1'b1;
        end
      end
      if (portDetected && pubPort_reg[8]) begin
        icChannelOut[pubPort_reg[7:0]] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // interrupt: sticky status cleared by read, gated by enable mask
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEn_reg <= '0;
      intStat_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (wrDone && addr == `OFS_INT_SET) begin
        intEn_reg <= intEn_reg | {pwdata[`INT_PORT_BIT], pwdata[NCH-1:0]};
      end else if (wrDone && addr == `OFS_INT_CLR) begin
        intEn_reg <= intEn_reg & ~{pwdata[`INT_PORT_BIT], pwdata[NCH-1:0]};
      end
      if (rdDone && addr == `OFS_INT_STATUS) begin
        intStat_reg <= eventsNow;
      end else begin
        intStat_reg <= intStat_reg | eventsNow;
      end
      irq <= |(intStat_reg & intEn_reg);
    end
  end

  // ************************************************************
  // pin multiplexer
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= '0;
      pinOe <= '0;
    end else begin
      for (int p = 0; p < `NUM_PINS; p++) begin
        pinOe[p] <= gpioPinConfigDir[p];
        pinOut[p] <= gpioPinConfigOut[p];
        // overlapping selections are undefined; the highest-numbered channel in event or task mode sets pinOe, the highest in task mode sets pinOut
        for (int c = 0; c < NCH; c++) begin
          if (pinSel_reg[c] == p[`PSEL_W-1:0]) begin
            if (mode_reg[c] == MODE_EVENT) begin
              pinOe[p] <= 1'b0;
            end else if (mode_reg[c] == MODE_TASK) begin
              pinOe[p] <= 1'b1;
              pinOut[p] <= level[c];
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // assertions on channels 0 and 1, all-channel passthrough and port event
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  event_pin_input_a: assert property (
    mode_reg[1] == MODE_EVENT && $stable(pinSel_reg[1]) |=> !pinOe[pinSel_reg[1]])
    else $error("event mode pin not input");
  task_pin_output_a: assert property (
    mode_reg[0] == MODE_TASK |=> pinOe[pinSel_reg[0]] && pinOut[pinSel_reg[0]] == $past(level[0]))
    else $error("task mode pin not driven by channel");
  disabled_passthru_a: assert property (
    (mode_reg[0] == MODE_DISABLED && mode_reg[1] == MODE_DISABLED &&
     mode_reg[2] == MODE_DISABLED && mode_reg[3] == MODE_DISABLED &&
     mode_reg[4] == MODE_DISABLED && mode_reg[5] == MODE_DISABLED &&
     mode_reg[6] == MODE_DISABLED && mode_reg[7] == MODE_DISABLED)
    |=> pinOe == $past(gpioPinConfigDir) && pinOut == $past(gpioPinConfigOut))
    else $error("disabled pin not from pin controller");
  psel_frozen_a: assert property (
    mode_reg[0] != MODE_DISABLED |=> $stable(pinSel_reg[0]))
    else $error("pin select moved while enabled");
  set_drives_high_a: assert property (
    mode_reg[0] == MODE_TASK && $past(mode_reg[0]) == MODE_TASK && setTrig[0] &&
    !clrTrig[0] && !outTrig[0] |=> level[0])
    else $error("set task did not drive high");
  clr_beats_set_a: assert property (
    mode_reg[0] == MODE_TASK && $past(mode_reg[0]) == MODE_TASK && setTrig[0] &&
    clrTrig[0] && !outTrig[0] |=> !level[0])
    else $error("clear did not win over set");
  out_none_holds_a: assert property (
    mode_reg[0] == MODE_TASK && $past(mode_reg[0]) == MODE_TASK && outTrig[0] &&
    pol_reg[0] == POL_NONE |=> $stable(level[0]))
    else $error("output task with no action changed pin");
  toggle_flips_a: assert property (
    mode_reg[0] == MODE_TASK && $past(mode_reg[0]) == MODE_TASK && outTrig[0] &&
    pol_reg[0] == POL_TOGGLE |=> level[0] != $past(level[0]))
    else $error("toggle did not flip pin");
  task_entry_init_a: assert property (
    mode_reg[0] == MODE_TASK && $past(mode_reg[0]) != MODE_TASK
    |=> level[0] == $past(initialOutputLevel_reg[0]))
    else $error("task entry level wrong");
  rise_sets_event_a: assert property (
    mode_reg[1] == MODE_EVENT && $past(mode_reg[1]) == MODE_EVENT &&
    pol_reg[1] == POL_LO_TO_HI && $rose(pinIn[pinSel_reg[1]]) |=> inEvent_reg[1])
    else $error("rising edge missed");
  port_event_set_a: assert property (
    $rose(senseDetect) |=> portEvent_reg ##1 intStat_reg[NCH])
    else $error("port event missed");

  toggle_seen_c: cover property (outTrig[0] && pol_reg[0] == POL_TOGGLE);
  event_seen_c: cover property (detected[1] ##2 irq);
  sub_fire_c: cover property (subFires(subSet_reg[0], icChannelIn));
endmodule : pin_task_event_unit

// [verification/pin_env_model.sv]
/*
  Far side of the pin task/event unit: the pads and outside world.
  Assumes pins are synchronous to clk and one driver per pin.
*/
`timescale 1ns/100ps
module pin_env_model (
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  input wire logic [31:0] extLevel,
  output logic [31:0] pinIn
);
  // pad reads back its own drive, else the outside level
  // each pin is stimulated by one source only
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pin_env_model

// [verification/pin_task_event_unit_tb.sv]
/*
  Self-checking bench of the pin task/event unit.
  Assumes the design package, header and pin_env_model are compiled first.
*/
`timescale 1ns/100ps
module pin_task_event_unit_tb;
  import pin_task_event_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, senseDetect = 0, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, pinOut, pinOe, pinIn;
  logic [31:0] gDir = 32'h0000_0200, gOut = 32'h0000_FFFF, ext = '0;
  logic [255:0] ic = '0, icOut;
  logic err;
  int num_errors = 0, n_checks = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] e;} row_t;
  row_t rows [10] = '{
    '{12'h510, 32'h0013_0503, 2'h3}, '{12'h060, 32'h1, 2'h2}, '{12'h030, 32'h1, 2'h3},
    '{12'h000, 32'h1, 2'h2}, '{12'h510, 32'h0003_0500, 2'h1}, '{12'h510, 32'h0001_0503, 2'h2},
    '{12'h000, 32'h1, 2'h3}, '{12'h510, 32'h0000_0500, 2'h1}, '{12'h510, 32'h0012_0503, 2'h3},
    '{12'h000, 32'h1, 2'h2}};
  pin_task_event_unit dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .gpioPinConfigDir(gDir), .gpioPinConfigOut(gOut), .senseDetect(senseDetect),
    .icChannelIn(ic), .icChannelOut(icOut), .irq(irq));
  pin_env_model pads_u (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
  always #10 clk = ~clk;
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (n >= 10) begin
      num_errors++;
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never writes psel twice at once
      @(posedge clk);
    end
  endtask : apb
  task automatic pulse(input logic [255:0] m);
    ic <= m;
    @(posedge clk);
    ic <= '0;
    tick(2);
  endtask : pulse
  function automatic logic [31:0] pin5();
    return {30'h0, pinOe[5], pinOut[5]};
  endfunction : pin5
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    check(pinOe, gDir);
    apb(0, 12'h0B4, 0); check(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      tick(2);
      check(pin5(), {30'h0, rows[i].e});
    end
    apb(1, 12'h0E4, 32'h8000_0009); apb(0, 12'h0E4, 0); check(rd, 32'h8000_0009);
    apb(1, 12'h0B0, 32'h8000_0007); pulse(256'h80); check(pin5(), 32'h3);
    apb(1, 12'h0E0, 32'h0000_0009); pulse(256'h200); check(pin5(), 32'h3);
    apb(1, 12'h0E0, 32'h8000_0009); pulse(256'h280); check(pin5(), 32'h2);
    apb(1, 12'h080, 32'h8000_0003); apb(1, 12'h510, 32'h0011_0503);
    pulse(256'h288); check(pin5(), 32'h3);
    apb(1, 12'h510, 32'h0010_0503); pulse(256'h288); check(pin5(), 32'h3);
    apb(1, 12'h510, 32'h0011_0603); tick(2);
    check({pinOe[6], pinOe[5]}, 2'b01);
    apb(1, 12'h510, 32'h0000_0500); apb(1, 12'h304, 32'h8000_0002);
    apb(1, 12'h184, 32'h8000_0005);
    apb(1, 12'h514, 32'h0001_0901); tick(3);
    check(pinOe[9], 1'b0);
    ext[9] <= 1'b1; tick(2);
    check(icOut[5], 1'b1);
    tick(1);
    check(irq, 1'b1);
    check(icOut[5], 1'b0);
    apb(0, 12'h104, 0); check(rd, 32'h1);
    apb(1, 12'h104, 0); apb(0, 12'h104, 0); check(rd, 32'h0);
    apb(0, 12'h30C, 0); check(rd, 32'h2);
    tick(2); check(irq, 1'b0);
    apb(1, 12'h308, 32'h2); ext[9] <= 1'b0; tick(2); ext[9] <= 1'b1; tick(3);
    apb(0, 12'h104, 0); check(rd, 32'h1);
    check(irq, 1'b0);
    senseDetect <= 1'b1; tick(3);
    apb(0, 12'h17C, 0); check(rd, 32'h1);
    check(irq, 1'b1);
    apb(0, 12'h30C, 0); check(rd, 32'h8000_0002);
    apb(0, 12'h400, 0); check(err, 1'b1);
    rst <= 1'b1; tick(2);
    check(pinOut, 32'h0);
    rst <= 1'b0; tick(2);
    check(pinOe, gDir);
    apb(0, 12'h17C, 0); check(rd, 32'h0);
    apb(0, 12'h514, 0); check(rd, 32'h0);
    wrap_up();
  end
endmodule : pin_task_event_unit_tb
